// [rtl/core_exec_map.svh]
`ifndef CORE_EXEC_MAP_SVH
`define CORE_EXEC_MAP_SVH

// opcode field encodings (3 to 7 bits) of the 14-bit instruction for the executed subset
`define OPC_CLEAR_FILE   7'h03
`define OPC_CLEAR_ACCUM  7'h02
`define OPC_DEC_FILE     6'h03
`define OPC_DEC_SKIP     6'h0b
`define OPC_INC_SKIP     6'h0f
`define OPC_BRANCH       3'h5
`define OPC_OR_LITERAL   6'h38
// field positions
`define OPC_MSB          13
`define OPC_WIDE_LSB     7
`define OPC_NARROW_LSB   8
`define OPC_BRANCH_LSB   11
`define LITERAL_MSB      7
`define FADDR_MSB        6
`define DEST_BIT         7
`define BRANCH_MSB       10
`define LATCH_PAGE_MSB   4
`define LATCH_PAGE_LSB   3
// reset values
`define ACCUM_RESET      8'h00
`define PC_RESET         13'h0000
`define ZERO_RESET       1'b0

`endif

// [rtl/core_exec_pkg.sv]
package core_exec_pkg;

  typedef enum logic [2:0] {
    nop_op                 = 3'b000,
    clear_file_reg_op      = 3'b001,
    decrement_file_op      = 3'b010,
    clear_accum_op         = 3'b011,
    decrement_skip_zero_op = 3'b100,
    increment_skip_zero_op = 3'b101,
    unconditional_branch_op = 3'b110,
    or_literal_accum_op    = 3'b111
  } op_e;

  // file register write request
  typedef struct packed {
    logic       en;
    logic [6:0] addr;
    logic [7:0] data;
  } file_wr_s;

endpackage

// [rtl/core_clear_count_branch_exec.sv]
// Overview of operation
// RULE1: clear file register writes zero to the register and sets zero flag.
// RULE2: decrement writes f minus one to accumulator or file; zero flag updated.
// RULE3: clear accumulator loads zero into accumulator and sets zero flag.
// RULE4: decrement-and-skip writes f minus one by destination bit; flags untouched.
// RULE5: decrement-and-skip with zero result discards next instruction, two cycles.
// RULE6: increment-and-skip writes f plus one by destination bit; flags untouched.
// RULE7: increment-and-skip wrapping to zero replaces next instruction with no-op.
// RULE8: branch loads its 11-bit immediate into program counter bits 10 to 0.
// RULE9: branch fills program counter bits 12 and 11 from latch bits 4 and 3.
// RULE10: branch always takes two cycles and affects no status flag.
// RULE11: or-literal ORs accumulator with 8-bit literal into accumulator; zero updated.
// RULE12: file operand is a 7-bit address; destination select is one bit.
// RULE13: zero flag is set when the 8-bit result is zero, cleared otherwise.
`timescale 1ns/1ps
`include "core_exec_map.svh"

module core_clear_count_branch_exec (
  input  wire logic                     i_mclk,
  input  wire logic                     i_reset,
  input  wire logic                     i_valid,
  input  wire logic [13:0]              i_instr,
  input  wire logic [7:0]               i_file_rdata,
  input  wire logic [7:0]               i_pc_high_latch,
  output logic [6:0]                    o_file_raddr,
  output core_exec_pkg::file_wr_s       o_file_wr,
  output logic [7:0]                    o_accum,
  output logic                          o_zero,
  output logic [12:0]                   o_pc,
  output logic                          o_pc_load,
  output logic                          o_flush,
  output logic                          o_busy
);
  import core_exec_pkg::*;

  op_e         op;
  logic [6:0]  faddr;
  logic        dest;
  logic [7:0]  literal;
  logic [1:0]  page_bits;
  logic [10:0] branch_target;
  logic [7:0]  next_result;
  logic        is_skip;
  logic        squash;
  logic        hit_clear_file;
  logic        hit_clear_accum;
  logic        hit_dec_file;
  logic        hit_dec_skip;
  logic        hit_inc_skip;
  logic        hit_branch;
  logic        hit_or_literal;
  logic        result_zero;
  logic        skip_taken;
  logic        branch_taken;
  logic        file_write;
  logic        accum_load;
  logic        accum_from_file;

  // operand fields
  assign faddr   = i_instr[`FADDR_MSB:0];    // see RULE12
  assign dest    = i_instr[`DEST_BIT];       // see RULE12
  assign literal = i_instr[`LITERAL_MSB:0];  // see RULE11

  // branch target pieces: immediate and latch page bits
  assign branch_target = i_instr[`BRANCH_MSB:0];                            // see RULE8
  assign page_bits     = i_pc_high_latch[`LATCH_PAGE_MSB:`LATCH_PAGE_LSB];  // see RULE9

  // opcode matches for the executed subset
  assign hit_clear_file  = (i_instr[`OPC_MSB:`OPC_WIDE_LSB] == `OPC_CLEAR_FILE);
  assign hit_clear_accum = (i_instr[`OPC_MSB:`OPC_WIDE_LSB] == `OPC_CLEAR_ACCUM);
  assign hit_dec_file    = (i_instr[`OPC_MSB:`OPC_NARROW_LSB] == `OPC_DEC_FILE);
  assign hit_dec_skip    = (i_instr[`OPC_MSB:`OPC_NARROW_LSB] == `OPC_DEC_SKIP);
  assign hit_inc_skip    = (i_instr[`OPC_MSB:`OPC_NARROW_LSB] == `OPC_INC_SKIP);
  assign hit_branch      = (i_instr[`OPC_MSB:`OPC_BRANCH_LSB] == `OPC_BRANCH);
  assign hit_or_literal  = (i_instr[`OPC_MSB:`OPC_NARROW_LSB] == `OPC_OR_LITERAL);

  // file read address follows the current operand, registered at the edge
  always_ff @(posedge i_mclk or posedge i_reset)
  begin
    if (i_reset)
      o_file_raddr <= 7'h00;
    else
      o_file_raddr <= faddr;
  end

  // decode the executed subset; a squashed slot decodes as no-op
  always_comb
  begin
    op = nop_op;
    if (!i_valid || squash)
      op = nop_op;
    else if (hit_clear_file)
      op = clear_file_reg_op;
    else if (hit_clear_accum)
      op = clear_accum_op;
    else if (hit_dec_file)
      op = decrement_file_op;
    else if (hit_dec_skip)
      op = decrement_skip_zero_op;
    else if (hit_inc_skip)
      op = increment_skip_zero_op;
    else if (hit_branch)
      op = unconditional_branch_op;
    else if (hit_or_literal)
      op = or_literal_accum_op;
  end

  // arithmetic result for the decoded op
  always_comb
  begin
    next_result = 8'h00;
    is_skip     = 1'b0;
    unique case (op)
      clear_file_reg_op:      next_result = 8'h00;                 // see RULE1
      clear_accum_op:         next_result = 8'h00;                 // see RULE3
      decrement_file_op:      next_result = i_file_rdata - 8'h01;  // see RULE2
      decrement_skip_zero_op:
      begin
        next_result = i_file_rdata - 8'h01;                        // see RULE4
        is_skip     = 1'b1;
      end
      increment_skip_zero_op:
      begin
        next_result = i_file_rdata + 8'h01;                        // see RULE6
        is_skip     = 1'b1;
      end
      or_literal_accum_op:    next_result = o_accum | literal;     // see RULE11
      unconditional_branch_op: next_result = 8'h00;
      nop_op:                 next_result = 8'h00;
    endcase
  end

  // qualifiers shared by the write, flag and squash logic
  assign result_zero     = (next_result == 8'h00);               // see RULE13
  assign skip_taken      = is_skip && result_zero;                // see RULE5 see RULE7
  assign branch_taken    = (op == unconditional_branch_op);       // see RULE10
  assign file_write      = (op == clear_file_reg_op)              // see RULE1
                        || ((op == decrement_file_op || is_skip) && dest);  // see RULE2
  assign accum_load      = (op == clear_accum_op) || (op == or_literal_accum_op);
  assign accum_from_file = (op == decrement_file_op || is_skip) && !dest;

  // second-cycle squash after a taken skip or a branch
  always_ff @(posedge i_mclk or posedge i_reset)
  begin
    if (i_reset)
      squash <= 1'b0;
    else if (branch_taken)
      squash <= 1'b1;                                 // see RULE10
    else if (skip_taken)
      squash <= 1'b1;                                 // see RULE5 see RULE7
    else
      squash <= 1'b0;
  end

  // flush marks the slot that is discarded next
  always_ff @(posedge i_mclk or posedge i_reset)
  begin
    if (i_reset)
      o_flush <= 1'b0;
    else
      o_flush <= branch_taken || skip_taken;          // see RULE5 see RULE7 see RULE10
  end

  // busy mirrors flush for the fetch stage
  always_ff @(posedge i_mclk or posedge i_reset)
  begin
    if (i_reset)
      o_busy <= 1'b0;
    else
      o_busy <= branch_taken || skip_taken;           // see RULE10
  end

  // file register write port
  always_ff @(posedge i_mclk or posedge i_reset)
  begin
    if (i_reset)
      o_file_wr <= '0;
    else
    begin
      o_file_wr.addr <= faddr;
      o_file_wr.data <= next_result;
      o_file_wr.en   <= file_write;                   // see RULE1 see RULE2
    end
  end

  // accumulator
  always_ff @(posedge i_mclk or posedge i_reset)
  begin
    if (i_reset)
      o_accum <= `ACCUM_RESET;
    else if (accum_load)
      o_accum <= next_result;                         // see RULE3 see RULE11
    else if (accum_from_file)
      o_accum <= next_result;                         // see RULE2 see RULE4 see RULE6
  end

  // zero flag; skip ops and the branch leave it alone
  always_ff @(posedge i_mclk or posedge i_reset)
  begin
    if (i_reset)
      o_zero <= `ZERO_RESET;
    else if (op == clear_file_reg_op || op == clear_accum_op)
      o_zero <= 1'b1;                                 // see RULE1 see RULE3
    else if (op == decrement_file_op || op == or_literal_accum_op)
      o_zero <= result_zero;                          // see RULE2 see RULE11 see RULE13
  end

  // load strobe for the fetch stage, one cycle per branch
  always_ff @(posedge i_mclk or posedge i_reset)
  begin
    if (i_reset)
      o_pc_load <= 1'b0;
    else
      o_pc_load <= branch_taken;                      // see RULE10
  end

  // branch target from immediate and latch page bits
  always_ff @(posedge i_mclk or posedge i_reset)
  begin
    if (i_reset)
      o_pc <= `PC_RESET;
    else if (branch_taken)
      o_pc <= {page_bits, branch_target};             // see RULE8 see RULE9
  end

endmodule

// [tb/core_exec_checker.sv]
`timescale 1ns/1ps
module core_exec_checker (
  input wire logic                     i_mclk,
  input wire logic                     i_reset,
  input wire logic                     i_valid,
  input wire logic [13:0]              i_instr,
  input wire logic [7:0]               i_file_rdata,
  input wire logic [7:0]               i_pc_high_latch,
  input wire core_exec_pkg::file_wr_s  o_file_wr,
  input wire logic [7:0]               o_accum,
  input wire logic                     o_zero,
  input wire logic [12:0]              o_pc,
  input wire logic                     o_pc_load,
  input wire logic                     o_flush,
  input wire logic                     o_busy
);
  import core_exec_pkg::*;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_reset);
  // instruction accepted outside a squash cycle
  wire take = i_valid && !o_flush;
  a_clear_file: assert property (take && i_instr[13:7] == 7'h03 |=> o_file_wr.en && o_file_wr.data == 8'h00 && o_zero) else $error("clear file wrong");
  a_clear_accum: assert property (take && i_instr[13:7] == 7'h02 |=> o_accum == 8'h00 && o_zero) else $error("clear accum wrong");
  a_dec_zero: assert property (take && i_instr[13:8] == 6'h03 |=> o_zero == ($past(i_file_rdata) == 8'h01)) else $error("decrement zero wrong");
  a_skip_dec: assert property (take && i_instr[13:8] == 6'h0b |=> o_flush == ($past(i_file_rdata) == 8'h01) && $stable(o_zero)) else $error("dec skip wrong");
  a_skip_inc: assert property (take && i_instr[13:8] == 6'h0f |=> o_flush == ($past(i_file_rdata) == 8'hff) && $stable(o_zero)) else $error("inc skip wrong");
  a_branch_pc: assert property (take && i_instr[13:11] == 3'h5 |=> o_pc_load && o_pc == {$past(i_pc_high_latch[4:3]), $past(i_instr[10:0])}) else $error("branch target wrong");
  a_branch_two: assert property (take && i_instr[13:11] == 3'h5 |=> o_flush && $stable(o_zero) ##1 !o_pc_load) else $error("branch timing wrong");
  a_or_lit: assert property (take && i_instr[13:8] == 6'h38 |=> o_accum == ($past(o_accum) | $past(i_instr[7:0])) && o_zero == (o_accum == 8'h00)) else $error("or literal wrong");
  a_squash_quiet: assert property (o_flush |=> !o_file_wr.en && !o_pc_load && !o_flush && !o_busy && $stable(o_accum) && $stable(o_zero)) else $error("squash not quiet");
endmodule
bind core_clear_count_branch_exec core_exec_checker chk_u (
  .i_mclk          (i_mclk),
  .i_reset         (i_reset),
  .i_valid         (i_valid),
  .i_instr         (i_instr),
  .i_file_rdata    (i_file_rdata),
  .i_pc_high_latch (i_pc_high_latch),
  .o_file_wr       (o_file_wr),
  .o_accum         (o_accum),
  .o_zero          (o_zero),
  .o_pc            (o_pc),
  .o_pc_load       (o_pc_load),
  .o_flush         (o_flush),
  .o_busy          (o_busy)
);

// [tb/core_clear_count_branch_exec_tb.sv]
`timescale 1ns/1ps
module core_clear_count_branch_exec_tb;
  import core_exec_pkg::*;
  logic        i_mclk = 0, i_reset = 1, i_valid = 0;
  logic [13:0] i_instr = 14'h0000;
  logic [7:0]  i_file_rdata = 8'h00, i_pc_high_latch = 8'h00, o_accum;
  logic [6:0]  o_file_raddr;
  file_wr_s    o_file_wr;
  logic [12:0] o_pc;
  logic        o_zero, o_pc_load, o_flush, o_busy;
  int          bad_count = 0, comparisons = 0, ticks = 0;
  always #2 i_mclk = ~i_mclk;
  core_clear_count_branch_exec dut_u (
    .i_mclk          (i_mclk),
    .i_reset         (i_reset),
    .i_valid         (i_valid),
    .i_instr         (i_instr),
    .i_file_rdata    (i_file_rdata),
    .i_pc_high_latch (i_pc_high_latch),
    .o_file_raddr    (o_file_raddr),
    .o_file_wr       (o_file_wr),
    .o_accum         (o_accum),
    .o_zero          (o_zero),
    .o_pc            (o_pc),
    .o_pc_load       (o_pc_load),
    .o_flush         (o_flush),
    .o_busy          (o_busy)
  );
  // present one instruction at the edge
  task op(input logic [13:0] ins, input logic [7:0] rd, input logic [7:0] lt = 8'h00);
    @(posedge i_mclk);
    i_valid <= 1'b1;
    i_instr <= ins;
    i_file_rdata <= rd;
    i_pc_high_latch <= lt;
  endtask
  task idle;
    @(posedge i_mclk);
    i_valid <= 1'b0;
    #1;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      bad_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task t_clear;
    op(14'h3855, 8'h00); idle; chk(o_accum, 8'h55);
    op(14'h01ff, 8'h09); idle; chk({o_file_wr, o_file_raddr}, {1'b1, 7'h7f, 8'h00, 7'h7f});
    chk(o_zero, 1'b1);
    op(14'h3800, 8'h00); idle; chk({o_accum, o_zero}, {8'h55, 1'b0});
    op(14'h0100, 8'h00); idle; chk({o_accum, o_zero}, {8'h00, 1'b1});
  endtask
  task t_dec;
    op(14'h0305, 8'h01); idle; chk({o_accum, o_zero}, {8'h00, 1'b1});
    op(14'h0385, 8'h00); idle; chk({o_file_wr, o_zero}, {1'b1, 7'h05, 8'hff, 1'b0});
  endtask
  task t_skip;
    op(14'h0b03, 8'h01); idle; chk({o_accum, o_flush, o_busy, o_zero}, {8'h00, 1'b1, 1'b1, 1'b0});
    op(14'h0b03, 8'h01); op(14'h38ff, 8'h00); idle; chk(o_accum, 8'h00);
    op(14'h0f8a, 8'hff); idle; chk({o_file_wr, o_flush}, {1'b1, 7'h0a, 8'h00, 1'b1});
    op(14'h0f0a, 8'h05); idle; chk({o_accum, o_flush, o_zero}, {8'h06, 1'b0, 1'b0});
  endtask
  task t_branch;
    op(14'h2fff, 8'h00, 8'h18); op(14'h0100, 8'h00); #1;
    chk({o_pc, o_pc_load, o_flush, o_busy}, {13'h1fff, 1'b1, 1'b1, 1'b1});
    idle; chk({o_accum, o_zero, o_pc_load}, {8'h06, 1'b0, 1'b0});
    op(14'h2800, 8'h00, 8'hef); idle; chk(o_pc, 13'h0800);
  endtask
  // reset in mid-run, then an instruction at the first edge after release
  task t_reset;
    @(posedge i_mclk);
    i_reset <= 1'b1;
    i_valid <= 1'b0;
    repeat (2) @(posedge i_mclk);
    i_reset <= 1'b0;
    i_valid <= 1'b1;
    i_instr <= 14'h3800;
    idle; chk({o_accum, o_zero, o_flush, o_busy, o_pc_load}, {8'h00, 1'b1, 3'h0});
    op(14'h2801, 8'h00, 8'h00); idle; chk({o_pc, o_pc_load}, {13'h0001, 1'b1});
  endtask
  task summarize;
    if (bad_count == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // reset, then the scenarios in turn
  initial
  begin
    repeat (16) @(posedge i_mclk);
    i_reset <= 1'b0;
    t_clear;
    t_dec;
    t_skip;
    t_branch;
    t_reset;
    summarize;
  end
  // hang guard
  always @(posedge i_mclk)
  begin
    ticks++;
    if (ticks == 500)
    begin
      bad_count++;
      summarize;
    end
  end
endmodule
